// [design/prs_regs.vh]
// Register map, field positions, reset values and timing for the regulator supervisor.
`ifndef PRS_REGS_VH
`define PRS_REGS_VH
`define PRS_CLK_NS 100
`define PRS_BEAT_NS 2000000
`define PRS_AW 8
`define PRS_IW 5
`define PRS_NCFG 19
`define PRS_R_CTRL 5'h00
`define PRS_R_DLO 5'h01
`define PRS_R_DHI 5'h02
`define PRS_R_INIT 5'h03
`define PRS_R_HOLD 5'h04
`define PRS_R_FWD 5'h05
`define PRS_R_REV 5'h06
`define PRS_R_LLVL 5'h07
`define PRS_R_LTIM 5'h08
`define PRS_R_SLTH 5'h09
`define PRS_R_SLDL 5'h0a
`define PRS_R_WKTH 5'h0b
`define PRS_R_WKDL 5'h0c
`define PRS_R_P1 5'h0d
`define PRS_R_P2 5'h10
`define PRS_R_STAT 5'h13
`define PRS_R_IRQS 5'h14
`define PRS_R_IRQM 5'h15
`define PRS_C_SW_LO 0
`define PRS_C_SW_HI 1
`define PRS_C_ISEP 2
`define PRS_C_ISTOP 3
`define PRS_C_OPSTOP 4
`define PRS_C_SLEEP 5
`define PRS_SW_NONE 2'h0
`define PRS_SW_TERM 2'h1
`define PRS_SW_AUTO 2'h2
`define PRS_RST_CTRL 16'h0000
`define PRS_RST_DLO 16'h07d0
`define PRS_RST_DHI 16'h1f40
`define PRS_RST_STEP 16'h0064
`define PRS_RST_SLTH 16'h1770
`define PRS_RST_WKTH 16'h07d0
`define PRS_RST_DLY 16'h001e
`define PRS_RST_PG 16'h00c8
`define PRS_RST_IG 16'h00c8
`define PRS_FULL 14'h2710
`define PRS_BEATS_10MS 22'h000005
`define PRS_BEATS_100MS 22'h000032
`define PRS_FRAC_SH 10
`define PRS_FRAC_ONE 11'h400
`define PRS_NIRQ 3
`define PRS_E_FAULT 0
`define PRS_E_SLEEP 1
`define PRS_E_WAKE 2
`endif

// [design/prs_top.v]
// Supervisor around a process regulator: gains, start hold, step limit, loss and sleep.
//
// What this block does
// R1 - Switchover setting: 0 none, 1 input terminal, 2 automatic by deviation.
// R2 - Switchover off: always use first gain set.
// R3 - Terminal mode: second set while gain-select terminal active, else first.
// R4 - Automatic: first set below low threshold, second set above high threshold.
// R5 - Between thresholds each gain blends linearly by deviation position.
// R6 - On start, output initial value for hold time, then regulate normally.
// R7 - Output change per 2 ms beat limited to configured step.
// R8 - Separate step limits for forward and reverse rotation, 0 to 100 percent.
// R9 - Separation enabled plus integral-pause terminal freezes integration.
// R10 - Stop-at-limit option halts integration while output at max or min.
// R11 - Feedback below loss level for loss time raises feedback-loss fault.
// R12 - Loss level zero disables loss judging.
// R13 - Stopped: 0 suspends computation, 1 keeps computing.
// R14 - Function select: 0 normal, 1 sleep and wake enabled.
// R15 - Feedback above sleep threshold for sleep delay enters sleep.
// R16 - Asleep, feedback below wake threshold for wake delay wakes.
// R17 - Timers restart from zero when their condition lapses before expiry.
// R18 - Gains, integral control, step limit and timers advance on the beat.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "prs_regs.vh"

module prs_top #(
    parameter BEAT_CYCLES = `PRS_BEAT_NS / `PRS_CLK_NS,
    parameter CW = 22
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PRS_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Drive side inputs, values in 0.01 percent
    input wire run_i,
    input wire reverse_i,
    input wire gain_select_term,
    input wire integral_pause_term,
    input wire [13:0] reference_i,
    input wire [13:0] feedback_i,
    input wire [13:0] regulator_calc_i,
    // Regulator and drive outputs
    output reg beat_r,
    output reg calc_en_r,
    output reg integral_hold_r,
    output reg gain_set2_r,
    output reg [15:0] kp_r,
    output reg [15:0] ki_r,
    output reg [15:0] kd_r,
    output reg [13:0] pid_out_r,
    output reg holding_r,
    output reg loss_fault_r,
    output reg asleep_r,
    output reg irq
);

    reg [15:0] cfg_r [0:`PRS_NCFG-1];
    reg [`PRS_NIRQ-1:0] irq_stat_r;
    reg [`PRS_NIRQ-1:0] irq_mask_r;
    reg [31:0] beat_cnt_r;
    reg [CW-1:0] hold_cnt_r;
    reg [CW-1:0] loss_cnt_r;
    reg [CW-1:0] slp_cnt_r;
    reg calc_en_d_r;
    integer i;

    function [15:0] rst_val;
        input integer idx;
        begin
            case (idx)
                `PRS_R_DLO: rst_val = `PRS_RST_DLO;
                `PRS_R_DHI: rst_val = `PRS_RST_DHI;
                `PRS_R_FWD, `PRS_R_REV: rst_val = `PRS_RST_STEP;
                `PRS_R_SLTH: rst_val = `PRS_RST_SLTH;
                `PRS_R_WKTH: rst_val = `PRS_RST_WKTH;
                `PRS_R_SLDL, `PRS_R_WKDL: rst_val = `PRS_RST_DLY;
                `PRS_R_P1, `PRS_R_P2: rst_val = `PRS_RST_PG;
                `PRS_R_P1 + 1, `PRS_R_P2 + 1: rst_val = `PRS_RST_IG;
                default: rst_val = `PRS_RST_CTRL;
            endcase
        end
    endfunction

    // Signed blend keeps the result between the two gains for any order of them.
    function [15:0] blend;
        input [15:0] g1;
        input [15:0] g2;
        input [10:0] frac;
        reg signed [28:0] d;
        begin
            d = ($signed({13'h0000, g2}) - $signed({13'h0000, g1}))
                * $signed({18'h00000, frac});
            blend = g1 + d[25:10];
        end
    endfunction

    wire [15:0] ctrl = cfg_r[`PRS_R_CTRL];
    wire [1:0] sw_mode = ctrl[`PRS_C_SW_HI:`PRS_C_SW_LO];

    // APB decode: zero wait states, data staged in the setup cycle.
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready;
    wire [`PRS_IW-1:0] idx = paddr[`PRS_IW+1:2];
    wire cfg_hit = idx < `PRS_NCFG;
    wire hit = cfg_hit | (idx == `PRS_R_STAT) | (idx == `PRS_R_IRQS)
        | (idx == `PRS_R_IRQM);

    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        if (cfg_hit)
            rd_mux = {16'h0000, cfg_r[idx]};
        else if (idx == `PRS_R_STAT)
            rd_mux = {25'h0000000, gain_set2_r, integral_hold_r, holding_r,
                calc_en_r, asleep_r, loss_fault_r, irq};
        else if (idx == `PRS_R_IRQS)
            rd_mux = {29'h00000000, irq_stat_r};
        else if (idx == `PRS_R_IRQM)
            rd_mux = {29'h00000000, irq_mask_r};
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_mask_r <= 3'h0;
            for (i = 0; i < `PRS_NCFG; i = i + 1)
                cfg_r[i] <= rst_val(i);
        end
        else
        begin
            pready <= 1'b1;
            if (setup)
            begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= ~hit;
            end
            if (wr_en && cfg_hit)
                cfg_r[idx] <= pwdata[15:0];
            if (wr_en && idx == `PRS_R_IRQM)
                irq_mask_r <= pwdata[`PRS_NIRQ-1:0];
        end
    end

    // Beat divider; 2 ms is far above 4096 cycles, so the count is a parameter.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            beat_cnt_r <= 32'h00000000;
            beat_r <= 1'b0;
        end
        else if (beat_cnt_r >= BEAT_CYCLES - 1)
        begin
            beat_cnt_r <= 32'h00000000;
            beat_r <= 1'b1; // R18
        end
        else
        begin
            beat_cnt_r <= beat_cnt_r + 32'h00000001;
            beat_r <= 1'b0;
        end
    end

    // Deviation and blend fraction for automatic gain switching.
    wire [13:0] dev = (reference_i > feedback_i) ? reference_i - feedback_i
        : feedback_i - reference_i;
    wire [13:0] dlo = cfg_r[`PRS_R_DLO][13:0];
    wire [13:0] dhi = cfg_r[`PRS_R_DHI][13:0];
    wire [23:0] frac_num = {dev - dlo, 10'h000};
    wire [23:0] frac_q = frac_num / {10'h000, dhi - dlo};
    wire [10:0] frac = frac_q[10:0];

    reg [10:0] gain_frac;
    always @*
    begin
        case (sw_mode)
            `PRS_SW_NONE: gain_frac = 11'h000; // R1 R2
            `PRS_SW_TERM: gain_frac = gain_select_term ? `PRS_FRAC_ONE : 11'h000; // R3
            `PRS_SW_AUTO:
            begin
                if (dev <= dlo)
                    gain_frac = 11'h000; // R4
                else if (dev >= dhi)
                    gain_frac = `PRS_FRAC_ONE; // R4
                else
                    gain_frac = frac; // R5
            end
            default: gain_frac = 11'h000;
        endcase
    end

    // Computation enable: stopped drive suspends unless told to keep going.
    wire calc_en = (run_i | ctrl[`PRS_C_OPSTOP]) & ~asleep_r; // R13
    wire start = calc_en & ~calc_en_d_r;
    wire [CW-1:0] hold_lim = {6'h00, cfg_r[`PRS_R_HOLD]} * `PRS_BEATS_10MS;
    wire [CW-1:0] loss_lim = {6'h00, cfg_r[`PRS_R_LTIM]} * `PRS_BEATS_100MS;
    wire [CW-1:0] sl_lim = {6'h00, cfg_r[`PRS_R_SLDL]} * `PRS_BEATS_100MS;
    wire [CW-1:0] wk_lim = {6'h00, cfg_r[`PRS_R_WKDL]} * `PRS_BEATS_100MS;
    wire [13:0] step = reverse_i ? cfg_r[`PRS_R_REV][13:0]
        : cfg_r[`PRS_R_FWD][13:0]; // R8
    wire [13:0] llvl = cfg_r[`PRS_R_LLVL][13:0];
    wire loss_cond = (llvl != 14'h0000) & (feedback_i < llvl); // R12
    wire sleep_en = ctrl[`PRS_C_SLEEP]; // R14
    wire sl_cond = feedback_i > cfg_r[`PRS_R_SLTH][13:0];
    wire wk_cond = feedback_i < cfg_r[`PRS_R_WKTH][13:0];
    wire at_limit = (pid_out_r == 14'h0000) | (pid_out_r >= `PRS_FULL);

    reg [13:0] out_nxt;
    always @*
    begin
        out_nxt = pid_out_r;
        if (holding_r || start)
            out_nxt = cfg_r[`PRS_R_INIT][13:0]; // R6
        else if (regulator_calc_i > pid_out_r)
            out_nxt = (regulator_calc_i - pid_out_r > step)
                ? pid_out_r + step : regulator_calc_i; // R7
        else
            out_nxt = (pid_out_r - regulator_calc_i > step)
                ? pid_out_r - step : regulator_calc_i; // R7
    end

    reg [`PRS_NIRQ-1:0] ev;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            calc_en_d_r <= 1'b0;
            calc_en_r <= 1'b0;
            holding_r <= 1'b0;
            hold_cnt_r <= {CW{1'b0}};
            loss_cnt_r <= {CW{1'b0}};
            slp_cnt_r <= {CW{1'b0}};
            loss_fault_r <= 1'b0;
            asleep_r <= 1'b0;
            integral_hold_r <= 1'b1;
            gain_set2_r <= 1'b0;
            kp_r <= `PRS_RST_PG;
            ki_r <= `PRS_RST_IG;
            kd_r <= 16'h0000;
            pid_out_r <= 14'h0000;
            ev <= 3'h0;
        end
        else
        begin
            ev <= 3'h0;
            calc_en_d_r <= calc_en;
            calc_en_r <= calc_en;
            // A start that meets a beat must not swallow the work of that beat.
            if (start)
            begin
                holding_r <= 1'b1; // R6
                hold_cnt_r <= {CW{1'b0}};
            end
            if (beat_r)
            begin
                kp_r <= blend(cfg_r[`PRS_R_P1], cfg_r[`PRS_R_P2], gain_frac); // R18
                ki_r <= blend(cfg_r[`PRS_R_P1+1], cfg_r[`PRS_R_P2+1], gain_frac);
                kd_r <= blend(cfg_r[`PRS_R_P1+2], cfg_r[`PRS_R_P2+2], gain_frac);
                gain_set2_r <= gain_frac == `PRS_FRAC_ONE;
                integral_hold_r <= ~calc_en
                    | (ctrl[`PRS_C_ISEP] & integral_pause_term) // R9
                    | (ctrl[`PRS_C_ISTOP] & at_limit); // R10
                if (calc_en)
                    pid_out_r <= out_nxt; // R7
                if (holding_r && calc_en && !start)
                begin
                    if (hold_cnt_r >= hold_lim)
                        holding_r <= 1'b0; // R6
                    else
                        hold_cnt_r <= hold_cnt_r + 1'b1;
                end
                // Loss judging runs only while run_i is active, even if computation continues; a stop clears the fault.
                if (!run_i)
                begin
                    loss_fault_r <= 1'b0;
                    loss_cnt_r <= {CW{1'b0}};
                end
                else if (!loss_cond)
                    loss_cnt_r <= {CW{1'b0}}; // R17
                else if (loss_cnt_r >= loss_lim)
                begin
                    if (!loss_fault_r)
                        ev[`PRS_E_FAULT] <= 1'b1;
                    loss_fault_r <= 1'b1; // R11
                end
                else
                    loss_cnt_r <= loss_cnt_r + 1'b1;
                // Sleep and wake share one timer since only one runs at a time.
                if (!sleep_en)
                begin
                    asleep_r <= 1'b0; // R14
                    slp_cnt_r <= {CW{1'b0}};
                end
                else if (!asleep_r)
                begin
                    if (!sl_cond || !run_i)
                        slp_cnt_r <= {CW{1'b0}}; // R17
                    else if (slp_cnt_r >= sl_lim)
                    begin
                        asleep_r <= 1'b1; // R15
                        slp_cnt_r <= {CW{1'b0}};
                        ev[`PRS_E_SLEEP] <= 1'b1;
                    end
                    else
                        slp_cnt_r <= slp_cnt_r + 1'b1;
                end
                else
                begin
                    if (!wk_cond)
                        slp_cnt_r <= {CW{1'b0}}; // R17
                    else if (slp_cnt_r >= wk_lim)
                    begin
                        asleep_r <= 1'b0; // R16
                        slp_cnt_r <= {CW{1'b0}};
                        ev[`PRS_E_WAKE] <= 1'b1;
                    end
                    else
                        slp_cnt_r <= slp_cnt_r + 1'b1;
                end
            end
        end
    end

    // Sticky events: a new event wins over a write-one-to-clear in the same cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_en && idx == `PRS_R_IRQS)
                irq_stat_r <= (irq_stat_r & ~pwdata[`PRS_NIRQ-1:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

// [tb/prs_monitor.sv]
// Port-level assertion checker for the regulator supervisor.
`timescale 1ns/1ps
module prs_monitor #(
    parameter BEAT_CYCLES = 20000
) (
    // Clock, reset and APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Drive side
    input wire run_i,
    input wire beat_r,
    input wire calc_en_r,
    input wire gain_set2_r,
    input wire [15:0] kp_r,
    input wire [13:0] pid_out_r,
    input wire holding_r,
    input wire loss_fault_r,
    input wire asleep_r
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reg [31:0] gap_r;
    reg seen_r;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_r <= 32'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r <= beat_r ? 32'h0 : gap_r + 32'h1;
            seen_r <= seen_r | beat_r;
        end
    end
    property p_beat;
        beat_r && seen_r |-> gap_r == BEAT_CYCLES - 1;
    endproperty
    a_beat: assert property (p_beat) else $error("beat spacing wrong");
    property p_gain;
        !beat_r |=> $stable(kp_r) && $stable(gain_set2_r);
    endproperty
    a_gain: assert property (p_gain) else $error("gain moved off beat");
    property p_out;
        !beat_r |=> $stable(pid_out_r);
    endproperty
    a_out: assert property (p_out) else $error("output moved off beat");
    property p_sleep;
        $rose(asleep_r) |-> $past(beat_r);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep off beat");
    property p_loss;
        $rose(loss_fault_r) |-> $past(beat_r) && $past(run_i);
    endproperty
    a_loss: assert property (p_loss) else $error("fault off beat");
    property p_run;
        $past(run_i) && !$past(asleep_r) |-> calc_en_r;
    endproperty
    a_run: assert property (p_run) else $error("not computing while run");
    property p_asleep;
        $past(asleep_r) |-> !calc_en_r;
    endproperty
    a_asleep: assert property (p_asleep) else $error("computing asleep");
    property p_hold;
        $rose(calc_en_r) |-> ##[0:1] holding_r;
    endproperty
    a_hold: assert property (p_hold) else $error("no start hold");
    property p_err;
        psel && !penable && paddr[6:2] > 5'h15 |=> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_rdy;
        $past(presetn) |-> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    c_sleep: cover property ($rose(asleep_r));
    c_loss: cover property ($rose(loss_fault_r));
    c_set2: cover property ($rose(gain_set2_r));
endmodule

// [tb/prs_plant.sv]
// Drive-side model: run state, terminals and process values.
`timescale 1ns/1ps
module prs_plant (
    // Clock
    input wire pclk,
    // Values toward the supervisor
    output reg run_i,
    output reg reverse_i,
    output reg gain_select_term,
    output reg integral_pause_term,
    output reg [13:0] reference_i,
    output reg [13:0] feedback_i,
    output reg [13:0] regulator_calc_i
);
    initial {run_i, reverse_i, gain_select_term, integral_pause_term} = 4'h0;
    initial {reference_i, feedback_i, regulator_calc_i} = 42'h0;
    // Changes land just after an edge so the beat never samples a half-updated set.
    task drive(input logic r, rv, gs, ip, input logic [13:0] rf, fb, cl);
        @(posedge pclk);
        run_i <= r;
        reverse_i <= rv;
        gain_select_term <= gs;
        integral_pause_term <= ip;
        reference_i <= rf;
        feedback_i <= fb;
        regulator_calc_i <= cl;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking testbench for the regulator supervisor.
`timescale 1ns/1ps
module testbench;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, run_i, reverse_i, gs, ip, beat_r, calc_en_r, ihold, set2;
    wire holding_r, loss_fault_r, asleep_r, irq;
    wire [13:0] ref_v, fb_v, calc_v, pid_out_r;
    wire [15:0] kp_r, ki_r, kd_r;
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] q;
    logic e;
    logic [13:0] p;
    always #50 pclk = ~pclk;
    prs_plant u_plant (.pclk(pclk), .run_i(run_i), .reverse_i(reverse_i),
        .gain_select_term(gs), .integral_pause_term(ip), .reference_i(ref_v),
        .feedback_i(fb_v), .regulator_calc_i(calc_v));
    prs_top #(.BEAT_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_i(run_i), .reverse_i(reverse_i),
        .gain_select_term(gs), .integral_pause_term(ip), .reference_i(ref_v),
        .feedback_i(fb_v), .regulator_calc_i(calc_v), .beat_r(beat_r), .calc_en_r(calc_en_r),
        .integral_hold_r(ihold), .gain_set2_r(set2), .kp_r(kp_r), .ki_r(ki_r), .kd_r(kd_r),
        .pid_out_r(pid_out_r), .holding_r(holding_r), .loss_fault_r(loss_fault_r),
        .asleep_r(asleep_r), .irq(irq));
    task chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer.
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task beats(input int n);
        repeat (n) @(posedge beat_r);
        @(posedge pclk);
        #1;
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #4000000;
        miscompares++;
        end_sim;
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, 8'h08, 0);
        chk(q, 32'h1f40);
        apb(0, 8'h14, 0);
        chk(q, 32'h64);
        apb(0, 8'h7c, 0);
        chk({31'h00000000, e}, 32'h00000001);
        chk(q, 32'h00000000);
        $display("register tests done");
        apb(1, 8'h54, 7);
        apb(1, 8'h34, 100);
        apb(1, 8'h40, 300);
        apb(1, 8'h44, 400);
        apb(1, 8'h48, 50);
        u_plant.drive(0, 0, 1, 0, 0, 0, 0);
        beats(2);
        chk({set2, kp_r}, 17'd100);
        chk({ki_r, kd_r}, {16'd200, 16'd0});
        apb(1, 8'h00, 1);
        beats(2);
        chk({set2, kp_r}, 17'h1012c);
        chk({ki_r, kd_r}, {16'd400, 16'd50});
        apb(1, 8'h00, 2);
        u_plant.drive(0, 0, 0, 0, 5000, 5000, 0);
        beats(2);
        chk(kp_r, 100);
        u_plant.drive(0, 0, 0, 0, 5000, 0, 0);
        beats(2);
        chk(kp_r, 200);
        chk({ki_r, kd_r}, {16'd300, 16'd25});
        u_plant.drive(0, 0, 0, 0, 9000, 0, 0);
        beats(2);
        chk(kp_r, 300);
        $display("gain tests done");
        apb(1, 8'h00, 4);
        apb(1, 8'h0c, 3000);
        apb(1, 8'h10, 1);
        u_plant.drive(1, 0, 0, 1, 0, 500, 5000);
        beats(2);
        chk({ihold, holding_r, pid_out_r}, 16'hcbb8);
        u_plant.drive(1, 0, 0, 0, 0, 500, 5000);
        beats(6);
        chk({ihold, holding_r, loss_fault_r}, 0);
        p = pid_out_r;
        beats(1);
        chk(pid_out_r, p + 14'd100);
        apb(1, 8'h18, 50);
        u_plant.drive(1, 1, 0, 0, 0, 500, 0);
        beats(1);
        p = pid_out_r;
        beats(1);
        chk(pid_out_r, p - 14'd50);
        $display("output tests done");
        apb(1, 8'h1c, 1000);
        beats(3);
        chk({irq, loss_fault_r}, 2'b11);
        apb(0, 8'h50, 0);
        chk(q, 1);
        apb(1, 8'h50, 1);
        apb(1, 8'h1c, 0);
        apb(1, 8'h00, 32'h20);
        apb(1, 8'h28, 0);
        apb(1, 8'h30, 0);
        u_plant.drive(1, 0, 0, 0, 0, 7000, 0);
        beats(3);
        chk({asleep_r, calc_en_r}, 2'b10);
        apb(0, 8'h50, 0);
        chk(q, 2);
        apb(1, 8'h50, 2);
        apb(1, 8'h54, 0);
        u_plant.drive(1, 0, 0, 0, 0, 1000, 0);
        beats(3);
        chk({asleep_r, irq}, 0);
        $display("sleep tests done");
        apb(1, 8'h0c, 0);
        apb(1, 8'h00, 32'h18);
        u_plant.drive(0, 0, 0, 0, 0, 1000, 0);
        beats(2);
        chk({calc_en_r, loss_fault_r, ihold}, 3'b101);
        apb(1, 8'h00, 32'h10);
        beats(1);
        chk({calc_en_r, ihold}, 2'b10);
        apb(1, 8'h00, 0);
        beats(1);
        chk(calc_en_r, 0);
        apb(1, 8'h20, 1);
        apb(1, 8'h1c, 2000);
        u_plant.drive(1, 0, 0, 0, 0, 1000, 0);
        beats(40);
        u_plant.drive(1, 0, 0, 0, 0, 3000, 0);
        beats(1);
        u_plant.drive(1, 0, 0, 0, 0, 1000, 0);
        beats(40);
        chk(loss_fault_r, 0);
        beats(12);
        chk(loss_fault_r, 1);
        $display("stop and loss timer tests done");
        end_sim;
    end
endmodule
bind prs_top prs_monitor #(.BEAT_CYCLES(BEAT_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_i(run_i), .beat_r(beat_r), .calc_en_r(calc_en_r),
    .gain_set2_r(gain_set2_r), .kp_r(kp_r), .pid_out_r(pid_out_r), .holding_r(holding_r),
    .loss_fault_r(loss_fault_r), .asleep_r(asleep_r));
